// [rtl/sbgpio_map.svh]
`ifndef SBGPIO_MAP_SVH
`define SBGPIO_MAP_SVH
// PIN_SEL_IDX and PIN_CFG_IDX are indices (byte address is four times the index); the rest are byte addresses
`define PIN_SEL_IDX 8'h13
`define PIN_CFG_IDX 8'h14
`define DATA_OUT0_ADDR 12'h100
`define DATA_OUT1_ADDR 12'h104
`define DATA_IN_ADDR 12'h108
`define EVT_STAT_ADDR 12'h10C
`define EVT_MASK_ADDR 12'h110
// Field positions
`define CFG_OE 0
`define CFG_OTYPE 1
`define CFG_PULLUP 2
`define CFG_LOCK 3
`define CFG_ETYPE 4
`define CFG_EPOL 5
`define CFG_DEB 6
`define SEL_PORT 4
// Reset values
`define CFG_RST_EVT 8'h44
`define CFG_RST_OUT 8'h05
`define SEL_RST 8'h00
`define DOUT0_RST 8'h3F
`define DOUT1_RST 8'h03
// Debounce time in microseconds and clock rate in MHz
`define DEB_TIME_US 15000
`define CLK_MHZ 100
`define DEB_CYCLES (`DEB_TIME_US * `CLK_MHZ)
`endif

// [rtl/sbgpio_pkg.sv]
package sbgpio_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [20:0] deb_cnt_type;
endpackage : sbgpio_pkg

// [rtl/standby_gpio_event_config.sv]
// The APB slave port was left to the implementer.
`include "sbgpio_map.svh"
`timescale 1ns/10ps
`default_nettype none
module standby_gpio_event_config
  import sbgpio_pkg::*;
#(
  parameter int DEB_CYCLES = `DEB_CYCLES
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rst_standby_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [5:0] i_bidir_in,
  output logic [5:0] o_bidir_out,
  output logic [5:0] o_bidir_oe,
  output logic [5:0] o_bidir_pullup,
  input wire logic [1:0] i_event_in,
  output logic [1:0] o_out_only,
  output logic [1:0] o_out_only_oe,
  output logic [1:0] o_out_only_pullup,
  input wire logic [1:0] i_plain_in,
  output logic [7:0] o_event_pending,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][6:0] cfg_evt;
    logic [1:0][3:0] cfg_out;
    byte_type sel;
    logic [5:0] dout0;
    logic [1:0] dout1;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [7:0] pend;
    logic [7:0] deb_val;
    logic [7:0] det_prev;
    logic [7:0][20:0] deb_cnt;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [31:0] rdata;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [7:0] pin_raw;
  logic [7:0] filt;
  logic [7:0] det;
  logic [7:0] win_rd;
  logic [2:0] pin_idx;
  logic port1;
  logic hit;

  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign port1 = st_reg.sel[`SEL_PORT];
  assign pin_idx = st_reg.sel[2:0];
  assign pin_raw = {i_event_in, i_bidir_in};

  generate
    genvar g;
    for (g = 0; g < 8; g++)
    begin : g_pin
      assign filt[g] = st_reg.cfg_evt[g][`CFG_DEB] ? st_reg.deb_val[g]
                                                   : st_reg.sync2[g];
      assign det[g] = st_reg.cfg_evt[g][`CFG_EPOL] ? filt[g] : !filt[g];
    end
  endgenerate

  always_comb
  begin
    win_rd = 8'h00;
    if (!port1)
    begin
      win_rd[6:4] = st_reg.cfg_evt[pin_idx][6:4];
      if (pin_idx < 3'd6)
        win_rd[3:0] = st_reg.cfg_evt[pin_idx][3:0];
    end
    else if (pin_idx < 3'd2)
    begin
      win_rd[3:0] = st_reg.cfg_out[pin_idx[0]];
      win_rd[`CFG_OE] = 1'b1;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    hit = 1'b1;
    st_next.sync1 = {i_plain_in, pin_raw};
    st_next.sync2 = st_reg.sync1;
    st_next.det_prev = det;
    for (int i = 0; i < 8; i++)
    begin
      if (st_reg.sync2[i] == st_reg.deb_val[i])
        st_next.deb_cnt[i] = 21'h0_0000;
      else if (st_reg.deb_cnt[i] >= 21'(DEB_CYCLES - 1))
      begin
        st_next.deb_val[i] = st_reg.sync2[i];
        st_next.deb_cnt[i] = 21'h0_0000;
      end
      else
        st_next.deb_cnt[i] = st_reg.deb_cnt[i] + 21'h0_0001;
      if (st_reg.cfg_evt[i][`CFG_ETYPE])
        st_next.pend[i] = det[i];
      else
        st_next.pend[i] = det[i] && !st_reg.det_prev[i];
    end
    st_next.rdata = 32'h0000_0000;
    if (rd_acc)
    begin
      case (i_paddr)
        {2'b00, `PIN_SEL_IDX, 2'b00}: st_next.rdata[7:0] = st_reg.sel;
        {2'b00, `PIN_CFG_IDX, 2'b00}: st_next.rdata[7:0] = win_rd;
        `DATA_OUT0_ADDR: st_next.rdata[5:0] = st_reg.dout0;
        `DATA_OUT1_ADDR: st_next.rdata[1:0] = st_reg.dout1;
        `DATA_IN_ADDR: st_next.rdata[9:0] = st_reg.sync2;
        `EVT_STAT_ADDR:
        begin
          st_next.rdata[7:0] = st_reg.stat;
          st_next.stat = 8'h00;
        end
        `EVT_MASK_ADDR: st_next.rdata[7:0] = st_reg.mask;
        default: hit = 1'b0;
      endcase
    end
    if (wr_acc)
    begin
      case (i_paddr)
        {2'b00, `PIN_SEL_IDX, 2'b00}: st_next.sel = wbyte & 8'h17;
        {2'b00, `PIN_CFG_IDX, 2'b00}:
        begin
          if (!port1)
          begin
            st_next.cfg_evt[pin_idx][6:4] = wbyte[6:4];
            if (pin_idx < 3'd6 && !st_reg.cfg_evt[pin_idx][`CFG_LOCK])
              st_next.cfg_evt[pin_idx][3:0] = wbyte[3:0];
          end
          else if (pin_idx < 3'd2 && !st_reg.cfg_out[pin_idx[0]][3])
            st_next.cfg_out[pin_idx[0]][3:1] = wbyte[3:1];
        end
        `DATA_OUT0_ADDR:
          for (int i = 0; i < 6; i++)
          begin
            if (!st_reg.cfg_evt[i][`CFG_LOCK])
              st_next.dout0[i] = wbyte[i];
          end
        `DATA_OUT1_ADDR:
          for (int i = 0; i < 2; i++)
          begin
            if (!st_reg.cfg_out[i][3])
              st_next.dout1[i] = wbyte[i];
          end
        `EVT_MASK_ADDR: st_next.mask = wbyte;
        default: hit = 1'b0;
      endcase
    end
    st_next.stat = st_next.stat | st_reg.pend;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_standby_n)
    begin
      st_reg <= '0;
      for (int i = 0; i < 8; i++)
        st_reg.cfg_evt[i] <= 7'(`CFG_RST_EVT);
      for (int i = 0; i < 2; i++)
        st_reg.cfg_out[i] <= 4'(`CFG_RST_OUT);
      st_reg.dout0 <= 6'(`DOUT0_RST);
      st_reg.dout1 <= 2'(`DOUT1_RST);
      // Idle pins sit high on their pull-ups; starting the filter and
      // the edge history there avoids a false event right after reset
      st_reg.sync1 <= 10'h3FF;
      st_reg.sync2 <= 10'h3FF;
      st_reg.deb_val <= 8'hFF;
      st_reg.det_prev <= 8'hFF;
    end
    else if (!i_rst_n)
    begin
      st_reg <= st_next;
      st_reg.sel <= `SEL_RST;
      st_reg.stat <= 8'h00;
      st_reg.mask <= 8'h00;
      st_reg.pend <= 8'h00;
      // Lock survives main reset, so locked pins keep config bits 3:0 and value; event fields 6:4 still reset
      for (int i = 0; i < 6; i++)
      begin
        if (!st_reg.cfg_evt[i][`CFG_LOCK])
        begin
          st_reg.cfg_evt[i] <= 7'(`CFG_RST_EVT);
          st_reg.dout0[i] <= 1'b1;
        end
        else
          st_reg.cfg_evt[i][6:4] <= 3'(`CFG_RST_EVT >> 4);
      end
      for (int i = 6; i < 8; i++)
        st_reg.cfg_evt[i] <= 7'(`CFG_RST_EVT);
      for (int i = 0; i < 2; i++)
      begin
        if (!st_reg.cfg_out[i][3])
        begin
          st_reg.cfg_out[i] <= 4'(`CFG_RST_OUT);
          st_reg.dout1[i] <= 1'b1;
        end
      end
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave; unmapped addresses give pslverr
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata = st_reg.rdata;
  assign o_event_pending = st_reg.pend;
  assign o_irq = |(st_reg.stat & st_reg.mask);

  generate
    genvar k;
    for (k = 0; k < 6; k++)
    begin : g_bidir
      assign o_bidir_out[k] = st_reg.dout0[k];
      assign o_bidir_oe[k] = st_reg.cfg_evt[k][`CFG_OE] &&
        (st_reg.cfg_evt[k][`CFG_OTYPE] || !st_reg.dout0[k]);
      assign o_bidir_pullup[k] = st_reg.cfg_evt[k][`CFG_PULLUP];
    end
    for (k = 0; k < 2; k++)
    begin : g_outonly
      assign o_out_only[k] = st_reg.dout1[k];
      assign o_out_only_oe[k] = st_reg.cfg_out[k][1] || !st_reg.dout1[k];
      assign o_out_only_pullup[k] = st_reg.cfg_out[k][2];
    end
  endgenerate

endmodule : standby_gpio_event_config
`default_nettype wire

// [tb/sbgpio_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Port checker
// ----------------
module sbgpio_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rst_standby_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [5:0] o_bidir_out,
  input wire logic [5:0] o_bidir_oe,
  input wire logic [5:0] o_bidir_pullup,
  input wire logic [1:0] o_out_only,
  input wire logic [7:0] o_event_pending,
  input wire logic o_irq
);
  logic rst_q;
  logic [11:0] wa_q;
  // Address written in the previous cycle, zero if none, so output changes can be traced to a cause
  always_ff @(posedge i_clk_sys)
  begin
    rst_q <= !(i_rst_n && i_rst_standby_n);
    wa_q <= (i_psel && i_penable && i_pwrite) ? i_paddr : 12'h000;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n || !i_rst_standby_n);
  property p_rdy;
    i_psel |-> o_pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err;
    i_psel && i_penable && i_paddr == 12'h000 |-> o_pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_pu;
    $changed(o_bidir_pullup) |-> rst_q || wa_q == 12'h050;
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up moved");
  property p_dout;
    $changed(o_bidir_out) |-> rst_q || wa_q == 12'h100;
  endproperty
  a_dout: assert property (p_dout) else $error("data moved");
  property p_oe;
    $changed(o_bidir_oe) |-> rst_q || wa_q inside {12'h050, 12'h100};
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved");
  property p_odout;
    $changed(o_out_only) |-> rst_q || wa_q == 12'h104;
  endproperty
  a_odout: assert property (p_odout) else $error("output moved");
  property p_irq;
    $rose(o_irq) |-> $past(o_event_pending) != 0 || wa_q == 12'h110;
  endproperty
  a_irq: assert property (p_irq) else $error("irq no cause");
  property p_rst;
    disable iff (!i_rst_standby_n) !i_rst_n |=> !o_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  c_irq: cover property (o_irq);
  c_err: cover property (o_pslverr);
  c_pend: cover property (o_event_pending != 0);
endmodule : sbgpio_chk
`default_nettype wire

// [tb/pin_partner.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------
// External pins
// ----------------
module pin_partner (
  input wire logic i_clk,
  input wire logic [5:0] i_out,
  input wire logic [5:0] i_oe,
  input wire logic [5:0] i_pu,
  input wire logic [5:0] i_drv,
  input wire logic [5:0] i_drv_en,
  output logic [5:0] o_pin
);
  // Floating lines wander so a stale level never looks valid
  logic [5:0] tgl = 6'h15;
  always @(posedge i_clk) tgl <= ~tgl;
  always_comb
    for (int b = 0; b < 6; b++)
      o_pin[b] = i_oe[b] ? i_out[b] : i_drv_en[b] ? i_drv[b] :
                 i_pu[b] ? 1'b1 : tgl[b];
endmodule : pin_partner
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
bind standby_gpio_event_config sbgpio_chk sbgpio_chk_inst (.*);
// ----------------
// Bench
// ----------------
module tb_top;
  import sbgpio_pkg::*;
  logic clk = 0, rst_n = 0, sb_n = 0, psel = 0, pen = 0, pw = 0;
  logic [11:0] pa = 0;
  logic [31:0] pd = 0, rd, prd;
  logic pr, pe, irq;
  logic [5:0] bo, boe, bpu, bin;
  logic [1:0] ev = 2'b01, oo, ooe, oopu;
  logic [7:0] pend;
  int err_total = 0, checks = 0, n;
  standby_gpio_event_config #(.DEB_CYCLES(8)) standby_gpio_event_config_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_rst_standby_n(sb_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
    .i_pwdata(pd), .o_prdata(prd), .o_pready(pr), .o_pslverr(pe),
    .i_bidir_in(bin), .o_bidir_out(bo), .o_bidir_oe(boe),
    .o_bidir_pullup(bpu), .i_event_in(ev), .o_out_only(oo),
    .o_out_only_oe(ooe), .o_out_only_pullup(oopu), .i_plain_in(2'b10),
    .o_event_pending(pend), .o_irq(irq));
  pin_partner pin_partner_inst (.i_clk(clk), .i_out(bo), .i_oe(boe),
    .i_pu(bpu), .i_drv(6'h00), .i_drv_en(6'h00), .o_pin(bin));
  initial forever #5 clk = ~clk;
  task test_done;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Read data lands one cycle late, so it is taken after the access edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pr !== 1'b1) @(posedge clk);
    psel <= 0;
    pen <= 0;
    #1 rd = prd;
  endtask : apb
  task rst(input logic sb);
    @(posedge clk);
    rst_n <= 0;
    sb_n <= !sb;
    @(posedge clk);
    rst_n <= 1;
    sb_n <= 1;
  endtask : rst
  task wfor(input logic v);
    n = 0;
    while (pend[7] !== v && n < 40)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wfor
  task cnt(input int k);
    n = 0;
    repeat (k)
    begin
      @(posedge clk);
      #1 n += (pend[7] === 1'b1);
    end
  endtask : cnt
  task t_sel;
    apb(0, 12'h04C, 0);
    chk("select", rd, 0);
    apb(0, 12'h050, 0);
    chk("cfg event pin", rd, 32'h0000_0044);
    apb(1, 12'h04C, 32'h0000_0010);
    apb(0, 12'h050, 0);
    chk("cfg out pin", rd, 32'h0000_0005);
    apb(1, 12'h050, 0);
    apb(0, 12'h050, 0);
    chk("enable fixed", rd, 32'h0000_0001);
    apb(1, 12'h04C, 32'h0000_0012);
    apb(0, 12'h050, 0);
    chk("plain pin", rd, 0);
    apb(0, 12'h000, 0);
    chk("unmapped", rd, 0);
  endtask : t_sel
  task t_lock;
    apb(1, 12'h04C, 0);
    apb(1, 12'h050, 32'h0000_000F);
    chk("drive", boe[0], 1);
    chk("pull-up", bpu[0], 1);
    apb(1, 12'h050, 0);
    apb(0, 12'h050, 0);
    chk("locked cfg", rd, 32'h0000_000F);
    apb(1, 12'h100, 0);
    chk("locked data", bo, 6'h01);
    apb(1, 12'h04C, 32'h0000_0001);
    apb(1, 12'h050, 32'h0000_0001);
    chk("drain low", boe[1], 1);
    apb(1, 12'h100, 32'h0000_0002);
    chk("drain high", boe[1], 0);
    rst(0);
    apb(0, 12'h050, 0);
    chk("lock kept", rd, 32'h0000_004F);
    rst(1);
    apb(0, 12'h050, 0);
    chk("lock freed", rd, 32'h0000_0044);
  endtask : t_lock
  task t_deb;
    apb(1, 12'h110, 32'h0000_0040);
    @(posedge clk) ev[0] <= 0;
    repeat (4) @(posedge clk);
    ev[0] <= 1;
    repeat (30) @(posedge clk);
    chk("glitch", irq, 0);
    // Drop events left by earlier scenarios before the real one
    apb(0, 12'h10C, 0);
    ev[0] <= 0;
    n = 0;
    while (irq !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("settle", n > 9 && n < 20, 1);
    apb(0, 12'h10C, 0);
    chk("status", rd[7:0], 8'h40);
    chk("cleared", irq, 0);
  endtask : t_deb
  task t_lvl;
    // Only existing pins are selected
    apb(1, 12'h04C, 32'h0000_0007);
    apb(1, 12'h050, 32'h0000_0070);
    @(posedge clk) ev[1] <= 1;
    wfor(1);
    chk("set delay", n > 9, 1);
    ev[1] <= 0;
    wfor(0);
    chk("clear delay", n > 9, 1);
    // Level notify wants no slow release
    apb(1, 12'h050, 32'h0000_0030);
    @(posedge clk) ev[1] <= 1;
    wfor(1);
    chk("bypass", n < 6, 1);
    cnt(10);
    chk("level", n, 10);
    apb(1, 12'h050, 32'h0000_0020);
    @(posedge clk) ev[1] <= 0;
    cnt(10);
    chk("wrong edge", n, 0);
    ev[1] <= 1;
    cnt(10);
    chk("edge pulse", n, 1);
    chk("masked", irq, 0);
  endtask : t_lvl
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    sb_n <= 1;
    t_sel();
    t_lock();
    t_deb();
    t_lvl();
    test_done();
  end
  initial
  begin
    #50000;
    err_total++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
